// [design/ccmsd_pkg.sv]
package ccmsd_pkg;

    // Stored word addresses of the two upper-bit and sign words.
    localparam logic [4:0] CCMSD_ADDR_BRIDGE_WORD = 5'h03;
    localparam logic [4:0] CCMSD_ADDR_TEMP_WORD = 5'h04;

    // Command codes: regular writes, regular reads, page increment.
    localparam logic [7:0] CCMSD_CMD_WRITE_FIRST = 8'h40;
    localparam logic [7:0] CCMSD_CMD_WRITE_LAST = 8'h57;
    localparam logic [7:0] CCMSD_CMD_READ_FIRST = 8'h20;
    localparam logic [7:0] CCMSD_CMD_READ_LAST = 8'h37;
    localparam logic [7:0] CCMSD_CMD_PAGE_INC = 8'h5e;

    // Pages run from 0 up to this last one; there is no way back.
    localparam logic [1:0] CCMSD_PAGE_LAST = 2'h3;
    localparam logic [1:0] CCMSD_PAGE_RESET = 2'h0;

    // Coefficient count and the index of the first temperature-path one.
    localparam int CCMSD_NCOEF = 10;
    localparam int CCMSD_FIRST_TEMP_IDX = 7;
    // Each coefficient owns two bits: magnitude bit 16, then sign.
    localparam int CCMSD_BITS_PER_COEF = 2;
    localparam int CCMSD_MAG_OFS = 0;
    localparam int CCMSD_SIGN_OFS = 1;

    // Extra fields in the bridge word.
    localparam int CCMSD_CURVE_BIT = 14;
    localparam int CCMSD_TREF_SIGN_BIT = 15;

    // Memory status word layout.
    localparam int CCMSD_STAT_CORR_BIT = 15;
    localparam int CCMSD_STAT_PAGE_HI = 14;
    localparam int CCMSD_STAT_PAGE_LO = 13;

    localparam logic [15:0] CCMSD_WORD_RESET = 16'h0000;
    localparam logic [1:0] CCMSD_WRITTEN_RESET = 2'h0;

    // Coefficient order: 0 bridge offset, 1 bridge gain, 2 gain tempco,
    // 3 offset tempco, 4 offset tempco sq, 5 gain tempco sq, 6 bridge sq,
    // 7 tsensor gain, 8 tsensor sq, 9 tsensor offset.
    typedef struct packed {
        logic negative;
        logic [16:0] magnitude;
    } ccmsd_coef_t;

    typedef ccmsd_coef_t [CCMSD_NCOEF-1:0] ccmsd_coef_vec_t;
    typedef logic [CCMSD_NCOEF-1:0][15:0] ccmsd_low_vec_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } ccmsd_cmd_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [15:0] data;
        logic [15:0] status;
    } ccmsd_rsp_t;

endpackage : ccmsd_pkg

// [design/ccmsd_decode.sv]
`timescale 1ns/100ps
// Functional notes
// - First word bit 0 is bridge offset magnitude bit 16; bit 1 its sign.
// - First word bit 2 is bridge gain magnitude bit 16; bit 3 its sign.
// - First word bit 4 is gain tempco magnitude bit 16; bit 5 its sign.
// - First word bit 6 is offset tempco magnitude bit 16; bit 7 its sign.
// - First word bit 8, 9: second-order offset tempco top bit, sign.
// - First word bit 10, 11: second-order gain tempco top bit, sign.
// - First word bit 12, 13: second-order bridge top bit, sign.
// - First word bit 14 picks curve: 0 parabolic, 1 s-shaped.
// - First word bit 15 is low-calibration temperature reference sign.
// - Second word bit 0, 1: temperature sensor gain top bit, sign.
// - Second word bit 2, 3: temperature sensor second-order top bit, sign.
// - Second word bit 4, 5: temperature sensor offset top bit, sign.
// - Sign bit 0 means positive, 1 negative, on the 17-bit magnitude.
// - One write per word per page; at most four pages in total.
module ccmsd_decode
    import ccmsd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire ccmsd_cmd_t cmd,
    input wire ccmsd_low_vec_t low_words,
    input wire logic [15:0] low_cal_temp_reference,
    output ccmsd_coef_vec_t coefs,
    output logic curve_shape_select,
    output logic low_cal_temp_ref_negative,
    output logic [15:0] low_cal_temp_ref_magnitude,
    output ccmsd_rsp_t rsp,
    output logic [1:0] page
);

    typedef struct packed {
        logic [15:0] bridge_word;
        logic [15:0] temp_word;
        logic [1:0] written;
        logic [1:0] page;
        ccmsd_coef_vec_t coefs;
        logic curve;
        logic tref_negative;
        logic [15:0] tref_magnitude;
        ccmsd_rsp_t rsp;
    } ccmsd_state_t;

    ccmsd_state_t state_q;
    ccmsd_state_t state_d;

    function automatic logic ccmsd_in_range(input logic [7:0] code,
                                           input logic [7:0] first,
                                           input logic [7:0] last);
        return (code >= first) && (code <= last);
    endfunction : ccmsd_in_range

    function automatic logic [4:0] ccmsd_word_addr(input logic [7:0] code,
                                                  input logic [7:0] base);
        logic [7:0] diff;
        diff = code - base;
        return diff[4:0];
    endfunction : ccmsd_word_addr

    // Decode straight from the stored words; one instance per coefficient.
    ccmsd_coef_vec_t decoded;

    generate
        for (genvar g = 0; g < CCMSD_NCOEF; g++) begin : g_coef
            localparam bit IS_TEMP = (g >= CCMSD_FIRST_TEMP_IDX);
            localparam int SLOT = IS_TEMP ? g - CCMSD_FIRST_TEMP_IDX : g;
            localparam int BASE = SLOT * CCMSD_BITS_PER_COEF;
            logic [15:0] src;
            // Temperature-path words only use bits 5:0 of the second word.
            assign src = IS_TEMP ? state_q.temp_word : state_q.bridge_word;
            // Top magnitude bit sits above the 16-bit low word.
            assign decoded[g].magnitude = {src[BASE + CCMSD_MAG_OFS],
                                           low_words[g]};
            // A set sign bit marks the coefficient negative.
            assign decoded[g].negative = src[BASE + CCMSD_SIGN_OFS];
        end
    endgenerate

    logic is_write;
    logic is_read;
    logic is_page_inc;
    logic [4:0] wr_addr;
    logic [4:0] rd_addr;
    logic hit_bridge;
    logic hit_temp;

    assign is_write = cmd.valid &&
        ccmsd_in_range(cmd.code, CCMSD_CMD_WRITE_FIRST, CCMSD_CMD_WRITE_LAST);
    assign is_read = cmd.valid &&
        ccmsd_in_range(cmd.code, CCMSD_CMD_READ_FIRST, CCMSD_CMD_READ_LAST);
    assign is_page_inc = cmd.valid && (cmd.code == CCMSD_CMD_PAGE_INC);
    assign wr_addr = ccmsd_word_addr(cmd.code, CCMSD_CMD_WRITE_FIRST);
    assign rd_addr = ccmsd_word_addr(cmd.code, CCMSD_CMD_READ_FIRST);
    assign hit_bridge = is_write && (wr_addr == CCMSD_ADDR_BRIDGE_WORD);
    assign hit_temp = is_write && (wr_addr == CCMSD_ADDR_TEMP_WORD);

    always_comb begin
        state_d = state_q;
        state_d.rsp.valid = 1'b0;
        state_d.rsp.refused = 1'b0;

        // Only the regular write codes reach the stored words.
        if (hit_bridge) begin
            // A second write in the same page is refused, not merged.
            if (state_q.written[0]) begin
                state_d.rsp.refused = 1'b1;
            end else begin
                state_d.bridge_word = cmd.data;
                state_d.written[0] = 1'b1;
            end
        end
        if (hit_temp) begin
            if (state_q.written[1]) begin
                state_d.rsp.refused = 1'b1;
            end else begin
                state_d.temp_word = cmd.data;
                state_d.written[1] = 1'b1;
            end
        end

        // Advancing the page wipes the old contents so they must be
        // programmed again; the last page can never be left.
        if (is_page_inc) begin
            if (state_q.page == CCMSD_PAGE_LAST) begin
                state_d.rsp.refused = 1'b1;
            end else begin
                state_d.page = state_q.page + 2'h1;
                state_d.bridge_word = CCMSD_WORD_RESET;
                state_d.temp_word = CCMSD_WORD_RESET;
                state_d.written = CCMSD_WRITTEN_RESET;
            end
        end

        // Reads answer with the word and the memory status word.
        if (is_read) begin
            state_d.rsp.valid = 1'b1;
            state_d.rsp.data = CCMSD_WORD_RESET;
            if (rd_addr == CCMSD_ADDR_BRIDGE_WORD) begin
                state_d.rsp.data = state_q.bridge_word;
            end else if (rd_addr == CCMSD_ADDR_TEMP_WORD) begin
                state_d.rsp.data = state_q.temp_word;
            end
            state_d.rsp.status = CCMSD_WORD_RESET;
            state_d.rsp.status[CCMSD_STAT_CORR_BIT] = 1'b0;
            state_d.rsp.status[CCMSD_STAT_PAGE_HI:CCMSD_STAT_PAGE_LO] =
                state_q.page;
        end

        // Outputs are registered so the correction math sees clean values;
        // this costs one cycle after a low word or stored word changes.
        state_d.coefs = decoded;
        // The temperature path ignores bits 15:6 of the second word.
        state_d.coefs[CCMSD_NCOEF-1:CCMSD_FIRST_TEMP_IDX] =
            decoded[CCMSD_NCOEF-1:CCMSD_FIRST_TEMP_IDX];
        state_d.curve = state_q.bridge_word[CCMSD_CURVE_BIT];
        state_d.tref_negative =
            state_q.bridge_word[CCMSD_TREF_SIGN_BIT];
        state_d.tref_magnitude = low_cal_temp_reference;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Everything clears: positive zero and parabolic curve.
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign coefs = state_q.coefs;
    assign curve_shape_select = state_q.curve;
    assign low_cal_temp_ref_negative = state_q.tref_negative;
    assign low_cal_temp_ref_magnitude = state_q.tref_magnitude;
    assign rsp = state_q.rsp;
    assign page = state_q.page;

endmodule : ccmsd_decode

// [test/ccmsd_decode_assertions.sv]
`timescale 1ns/100ps
module ccmsd_chk
    import ccmsd_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire ccmsd_cmd_t cmd,
    input wire ccmsd_low_vec_t low_words,
    input wire logic [15:0] low_cal_temp_reference,
    input wire ccmsd_coef_vec_t coefs,
    input wire logic curve_shape_select,
    input wire logic low_cal_temp_ref_negative,
    input wire logic [15:0] low_cal_temp_ref_magnitude,
    input wire ccmsd_rsp_t rsp,
    input wire logic [1:0] page
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A refused write changes nothing, so decode checks wait for acceptance.
    sequence ok(logic [7:0] c);
        cmd.valid && cmd.code == c ##1 !rsp.refused;
    endsequence
    a_bridge_low: assert property (ok(8'h43) |=>
        {coefs[3][17:16], coefs[2][17:16], coefs[1][17:16],
        coefs[0][17:16]} == $past(cmd.data[7:0], 2)) else $error("bridge lo");
    a_bridge_sq: assert property (ok(8'h43) |=>
        {coefs[6][17:16], coefs[5][17:16], coefs[4][17:16]}
        == $past(cmd.data[13:8], 2)) else $error("bridge sq");
    a_curve_tref: assert property (ok(8'h43) |=>
        {low_cal_temp_ref_negative, curve_shape_select}
        == $past(cmd.data[15:14], 2)) else $error("curve or ref sign");
    a_temp_fields: assert property (
        ok(8'h44) |=>
        {coefs[9][17:16], coefs[8][17:16], coefs[7][17:16]}
        == $past(cmd.data[5:0], 2)) else $error("temp fields");
    a_low_follow: assert property ($past(rst_n) |->
        coefs[0][15:0] == $past(low_words[0]) &&
        coefs[9][15:0] == $past(low_words[9])) else $error("low word");
    a_twice_refused: assert property (cmd.valid && cmd.code == 8'h43
        ##1 cmd.valid && cmd.code == 8'h43 |=> rsp.refused)
        else $error("rewrite");
    a_page_step: assert property (cmd.valid && cmd.code == 8'h5e &&
        page != 2'h3 |=> page == $past(page) + 2'h1) else $error("page step");
    a_page_last: assert property (cmd.valid && cmd.code == 8'h5e &&
        page == 2'h3 |=> rsp.refused && page == 2'h3) else $error("page end");
    c_write: cover property (ok(8'h44));
    c_read: cover property (rsp.valid);
    c_page_end: cover property (cmd.valid && cmd.code == 8'h5e && page == 2'h3);
endmodule : ccmsd_chk
bind ccmsd_decode ccmsd_chk ccmsd_chk_inst (.clock, .rst_n, .cmd,
    .low_words, .low_cal_temp_reference, .coefs, .curve_shape_select,
    .low_cal_temp_ref_negative, .low_cal_temp_ref_magnitude, .rsp, .page);

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
    import ccmsd_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    ccmsd_cmd_t cmd = '0;
    ccmsd_low_vec_t low_words;
    logic [15:0] low_cal_temp_reference = 16'h8123;
    ccmsd_coef_vec_t coefs;
    logic curve_shape_select;
    logic low_cal_temp_ref_negative;
    logic [15:0] low_cal_temp_ref_magnitude;
    ccmsd_rsp_t rsp;
    logic [1:0] page;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 clock = ~clock;
    ccmsd_decode ccmsd_decode_inst (.clock, .rst_n, .cmd, .low_words,
        .low_cal_temp_reference, .coefs, .curve_shape_select,
        .low_cal_temp_ref_negative, .low_cal_temp_ref_magnitude, .rsp, .page);
    task automatic tally_and_finish;
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_coef(input ccmsd_coef_t got, input ccmsd_coef_t exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t coef got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_coef
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t word got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(posedge clock);
        cmd <= '{1'b1, code, data};
        @(posedge clock);
        cmd.valid <= 1'b0;
        #1;
    endtask : send
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
        input logic [1:0] pg);
        send(a, 16'h0000);
        chk_flag({2'h0, rsp.valid}, 3'h1);
        chk_word(rsp.data, e);
        // Status bits below the page field are always zero, and are not compared.
        chk_flag(rsp.status[CCMSD_STAT_CORR_BIT:CCMSD_STAT_PAGE_LO],
            {1'b0, pg});
    endtask : rd
    task automatic check_all(input logic [15:0] bw, input logic [15:0] tw);
        logic [1:0] f;
        @(posedge clock);
        #1;
        for (int i = 0; i < CCMSD_NCOEF; i++) begin
            f = (i < CCMSD_FIRST_TEMP_IDX) ? bw[2*i+:2] : tw[2*(i-7)+:2];
            chk_coef(coefs[i], {f, low_words[i]});
        end
        chk_flag({1'b0, low_cal_temp_ref_negative, curve_shape_select},
            {1'b0, bw[15:14]});
        chk_word(low_cal_temp_ref_magnitude,
            low_cal_temp_reference);
    endtask : check_all
    task automatic scen_reset_defaults;
        check_all(16'h0000, 16'h0000);
    endtask : scen_reset_defaults
    task automatic scen_first_page;
        send(8'h43, 16'h5555);
        chk_flag({2'h0, rsp.refused}, 3'h0);
        send(8'h44, 16'hffea);
        check_all(16'h5555, 16'hffea);
        rd(8'h23, 16'h5555, 2'h0);
        rd(8'h24, 16'hffea, 2'h0);
        rd(8'h25, 16'h0000, 2'h0);
        // A write code with no decoded word behind it is dropped quietly.
        send(8'h45, 16'hffff);
        chk_flag({2'h0, rsp.refused}, 3'h0);
        check_all(16'h5555, 16'hffea);
    endtask : scen_first_page
    task automatic scen_rewrite_refused;
        // Two writes back to back to a word already set in this page.
        @(posedge clock);
        cmd <= '{1'b1, 8'h43, 16'h0f0f};
        @(posedge clock);
        cmd.data <= 16'hf0f0;
        #1;
        chk_flag({2'h0, rsp.refused}, 3'h1);
        @(posedge clock);
        cmd.valid <= 1'b0;
        low_words[3] <= 16'h0001;
        #1;
        chk_flag({2'h0, rsp.refused}, 3'h1);
        check_all(16'h5555, 16'hffea);
    endtask : scen_rewrite_refused
    task automatic scen_next_page;
        send(8'h5e, 16'h0000);
        chk_flag({rsp.refused, page}, 3'h1);
        check_all(16'h0000, 16'h0000);
        send(8'h43, 16'haaaa);
        send(8'h44, 16'h0015);
        check_all(16'haaaa, 16'h0015);
        rd(8'h23, 16'haaaa, 2'h1);
    endtask : scen_next_page
    task automatic scen_page_exhaust;
        send(8'h5e, 16'h0000);
        send(8'h5e, 16'h0000);
        chk_flag({rsp.refused, page}, 3'h3);
        send(8'h5e, 16'h0000);
        chk_flag({rsp.refused, page}, 3'h7);
    endtask : scen_page_exhaust
    always @(posedge clock) begin
        cyc++;
        if (cyc == 400) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        for (int i = 0; i < CCMSD_NCOEF; i++) begin
            low_words[i] = 16'(16'h9c35 + 16'h1111 * i);
        end
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        scen_reset_defaults();
        scen_first_page();
        scen_rewrite_refused();
        scen_next_page();
        scen_page_exhaust();
        tally_and_finish;
    end
endmodule : tb
